// ==== verilog/ssq_consts.vh ====
// Constants of the scan sequencer: register map, fields, reset values, timing
`ifndef SSQ_CONSTS_VH
`define SSQ_CONSTS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SSQ_REG_CTRL 8'h00
`define SSQ_REG_LIST 8'h04
`define SSQ_REG_IVAL 8'h08
`define SSQ_REG_GAP 8'h0c
`define SSQ_REG_STAT 8'h10
`define SSQ_REG_DIO 8'h14
`define SSQ_REG_TOT 8'h18
`define SSQ_REG_RIDX 8'h1c
`define SSQ_REG_RDAT 8'h20
`define SSQ_REG_RTS 8'h24

// ****************************************
// Control fields
// ****************************************
`define SSQ_C_START 0
`define SSQ_C_STOP 1
`define SSQ_C_SWTRIG 2
`define SSQ_C_SRC_LO 3
`define SSQ_C_SRC_HI 5
`define SSQ_C_FALL 6
`define SSQ_C_RDCLR 7
`define SSQ_C_AUTO 8
`define SSQ_C_RES_LO 9
`define SSQ_C_RES_HI 10
`define SSQ_C_WORD 11

// Trigger sources
`define SSQ_SRC_TIMER 3'h0
`define SSQ_SRC_KEY 3'h1
`define SSQ_SRC_SOFT 3'h2
`define SSQ_SRC_EXT 3'h3
`define SSQ_SRC_ALARM 3'h4

// ****************************************
// Channels, store, reset values
// ****************************************
`define SSQ_CH_PORTA 4'hd
`define SSQ_CH_PORTB 4'he
`define SSQ_CH_TOT 4'hf
`define SSQ_CH_LAST 4'hf
`define SSQ_DEPTH 50000
`define SSQ_DEPTH_M1 16'hc34f
`define SSQ_DEPTH_17 17'h0c350
`define SSQ_TOT_W 26
`define SSQ_CTRL_RST 12'h100
`define SSQ_IVAL_RST 32'h0001e848
`define SSQ_GAP_RST 32'h00000000

// Timing: fastest legal totalizer rate
`define SSQ_TOT_MAX_KHZ 100
`define SSQ_CLK_KHZ 125000
`define SSQ_TOT_MIN_CYC (`SSQ_CLK_KHZ / `SSQ_TOT_MAX_KHZ)

`endif

// ==== verilog/ssq_top.v ====
// Scan sequencer with digital input ports and pulse totalizer
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.vh"

module ssq_top
(
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Classic Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Sweep onset sources
  input wire key_press,
  input wire ext_trig,
  input wire alarm_logged,
  // Measurement path and external meter pacing
  output reg [3:0] mux_sel,
  output reg mux_en,
  output reg chan_closed,
  input wire meas_done,
  input wire [21:0] meas_data,
  output reg range_auto,
  output reg [1:0] res_sel,
  // Multifunction inputs
  input wire [7:0] din_a,
  input wire [7:0] din_b,
  input wire tot_in,
  // Status
  output reg scan_active
);

  // ****************************************
  // Local states and helpers
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_SEEK = 3'h1;
  localparam S_MEAS = 3'h2;
  localparam S_STORE = 3'h3;
  localparam S_GAP = 3'h4;

  // Channel membership in the list
  function listed;
    input [15:0] lst;
    input [3:0] ch;
    begin
      listed = lst[ch];
    end
  endfunction

  // Channels served without the meter
  function is_local;
    input [3:0] ch;
    begin
      is_local = (ch == `SSQ_CH_PORTA) || (ch == `SSQ_CH_PORTB) || (ch == `SSQ_CH_TOT);
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  reg [11:0] ctrl_q; // Mode bits
  reg [15:0] list_q; // One bit per channel
  reg [31:0] ival_q; // Sweep period in cycles
  reg [31:0] gap_q; // Wait between channels in cycles
  reg [15:0] ridx_q; // Logical read index, zero is oldest
  reg [2:0] st_q; // Sequencer state
  reg [3:0] ch_q; // Channel under test
  reg [31:0] tmr_q; // Interval timer
  reg [31:0] gcnt_q; // Inter-channel wait counter
  reg [31:0] stamp_q; // Time since scan start
  reg [15:0] wptr_q; // Next store slot
  reg [16:0] fill_q; // Readings held
  reg ovf_q; // Store wrapped
  reg pend_q; // Sweep requested while busy
  reg [31:0] mem_dat [0:`SSQ_DEPTH-1]; // Readings with channel tag
  reg [31:0] mem_ts [0:`SSQ_DEPTH-1]; // Matching time stamps
  reg [31:0] sample_q; // Reading about to be stored
  reg key_q; // Previous key level
  reg ext_q; // Previous trigger level
  reg [1:0] tsync_q; // Totalizer synchroniser
  reg tprev_q; // Last synchronised level
  reg [`SSQ_TOT_W-1:0] tot_q; // Pulse count

  wire [2:0] src = ctrl_q[`SSQ_C_SRC_HI:`SSQ_C_SRC_LO];
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire rd = acc & ~wb_we_i;
  wire start_cmd = wr && (wb_adr_i == `SSQ_REG_CTRL) && wb_dat_i[`SSQ_C_START];
  wire stop_cmd = wr && (wb_adr_i == `SSQ_REG_CTRL) && wb_dat_i[`SSQ_C_STOP];
  wire sw_cmd = wr && (wb_adr_i == `SSQ_REG_CTRL) && wb_dat_i[`SSQ_C_SWTRIG];

  // ****************************************
  // Sweep onset selection
  // ****************************************
  reg trig; // One-cycle onset request
  always @*
  begin
    case (src)
      `SSQ_SRC_TIMER: trig = scan_active && (tmr_q == 32'h0);
      `SSQ_SRC_KEY: trig = key_press & ~key_q;
      `SSQ_SRC_SOFT: trig = sw_cmd;
      `SSQ_SRC_EXT: trig = ext_trig & ~ext_q;
      `SSQ_SRC_ALARM: trig = alarm_logged;
      default: trig = 1'b0;
    endcase
  end

  // Edge memory for level-type onset inputs
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      key_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      key_q <= key_press;
      ext_q <= ext_trig;
    end
  end

  // Interval timer reloads each period; only runs while scanning
  always @(posedge clk)
  begin
    if (sys_rst || start_cmd)
      tmr_q <= 32'h0;
    else if (scan_active)
    begin
      if (tmr_q == 32'h0)
        tmr_q <= ival_q;
      else
        tmr_q <= tmr_q - 32'h1;
    end
  end

  // ****************************************
  // Totalizer
  // ****************************************
  // Two-flop synchroniser; only the second stage is looked at
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      always @(posedge clk)
      begin
        if (sys_rst)
          tsync_q[gi] <= 1'b0;
        else if (gi == 0)
          tsync_q[gi] <= tot_in;
        else
          tsync_q[gi] <= tsync_q[gi-1];
      end
    end
  endgenerate

  wire tedge = ctrl_q[`SSQ_C_FALL] ? (tprev_q & ~tsync_q[1]) : (~tprev_q & tsync_q[1]);
  wire tot_rd = rd && (wb_adr_i == `SSQ_REG_TOT);
  wire scan_tot = (st_q == S_SEEK) && listed(list_q, ch_q) && (ch_q == `SSQ_CH_TOT) && scan_active;
  wire tclr = ctrl_q[`SSQ_C_RDCLR] && (tot_rd || scan_tot);

  // Counter: sampling at 125 MHz follows 100 kHz pulses with ample margin
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tprev_q <= 1'b0;
      tot_q <= {`SSQ_TOT_W{1'b0}};
    end
    else
    begin
      tprev_q <= tsync_q[1];
      if (tclr)
        tot_q <= tedge ? {{(`SSQ_TOT_W-1){1'b0}}, 1'b1} : {`SSQ_TOT_W{1'b0}};
      else if (tedge)
        tot_q <= tot_q + {{(`SSQ_TOT_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Value of a local channel; word mode joins both ports
  reg [31:0] local_val;
  always @*
  begin
    local_val = 32'h0;
    if (ch_q == `SSQ_CH_TOT)
      local_val = {6'h0, tot_q};
    else if (ctrl_q[`SSQ_C_WORD])
      local_val = {16'h0, din_b, din_a};
    else if (ch_q == `SSQ_CH_PORTA)
      local_val = {24'h0, din_a};
    else
      local_val = {24'h0, din_b};
  end

  // Port B is folded into port A's entry in word mode
  wire skip_b = ctrl_q[`SSQ_C_WORD] && (ch_q == `SSQ_CH_PORTB);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= S_IDLE;
      ch_q <= 4'h0;
      mux_sel <= 4'h0;
      mux_en <= 1'b0;
      chan_closed <= 1'b0;
      gcnt_q <= 32'h0;
      sample_q <= 32'h0;
      scan_active <= 1'b0;
      pend_q <= 1'b0;
      wptr_q <= 16'h0;
      fill_q <= 17'h0;
      ovf_q <= 1'b0;
      stamp_q <= 32'h0;
    end
    else
    begin
      chan_closed <= 1'b0;
      stamp_q <= stamp_q + 32'h1;
      if (trig && st_q != S_IDLE)
        pend_q <= 1'b1;
      if (start_cmd)
      begin
        // Fresh scan: old readings are dropped before anything runs
        wptr_q <= 16'h0;
        fill_q <= 17'h0;
        ovf_q <= 1'b0;
        stamp_q <= 32'h0;
        scan_active <= 1'b1;
        st_q <= S_IDLE;
        mux_en <= 1'b0;
        pend_q <= 1'b0;
      end
      else if (stop_cmd)
      begin
        scan_active <= 1'b0;
        st_q <= S_IDLE;
        mux_en <= 1'b0;
      end
      else
      begin
        case (st_q)
          S_IDLE:
          begin
            if (scan_active && (trig || pend_q))
            begin
              pend_q <= 1'b0;
              ch_q <= 4'h0;
              st_q <= S_SEEK;
            end
          end
          S_SEEK:
          begin
            if (listed(list_q, ch_q) && !skip_b)
            begin
              if (is_local(ch_q))
              begin
                sample_q <= {ch_q, 2'h0, local_val[25:0]};
                st_q <= S_STORE;
              end
              else
              begin
                // Close one relay and tell the meter to go
                mux_sel <= ch_q;
                mux_en <= 1'b1;
                chan_closed <= 1'b1;
                st_q <= S_MEAS;
              end
            end
            else if (ch_q == `SSQ_CH_LAST)
              st_q <= S_IDLE;
            else
              ch_q <= ch_q + 4'h1;
          end
          S_MEAS:
          begin
            // Hold the channel until the meter reports completion
            if (meas_done)
            begin
              mux_en <= 1'b0;
              sample_q <= {ch_q, 6'h0, meas_data};
              st_q <= S_STORE;
            end
          end
          S_STORE:
          begin
            // Circular store; newest always kept
            if (wptr_q == `SSQ_DEPTH_M1)
            begin
              wptr_q <= 16'h0;
              ovf_q <= 1'b1;
            end
            else
              wptr_q <= wptr_q + 16'h1;
            if (fill_q != `SSQ_DEPTH_17)
              fill_q <= fill_q + 17'h1;
            gcnt_q <= gap_q;
            if (ch_q == `SSQ_CH_LAST)
              st_q <= S_IDLE;
            else
            begin
              ch_q <= ch_q + 4'h1;
              st_q <= S_GAP;
            end
          end
          S_GAP:
          begin
            // Wait after each stored channel except the last, SSQ_CH_LAST
            if (gcnt_q == 32'h0)
              st_q <= S_SEEK;
            else
              gcnt_q <= gcnt_q - 32'h1;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Store writes happen only from the store state of a running scan
  always @(posedge clk)
  begin
    if (st_q == S_STORE && scan_active && !start_cmd && !stop_cmd)
    begin
      mem_dat[wptr_q] <= sample_q;
      mem_ts[wptr_q] <= stamp_q;
    end
  end

  // Logical index to slot: oldest entry sits at the write pointer once wrapped
  wire [16:0] rsum = {1'b0, ridx_q} + (ovf_q ? {1'b0, wptr_q} : 17'h0);
  // Depth kept at the width of the sum so the wrap subtraction stays 17 bits
  wire [16:0] rphys17 = (rsum >= `SSQ_DEPTH_17) ? rsum - `SSQ_DEPTH_17 : rsum;
  wire [15:0] rphys = rphys17[15:0];

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state: ack a cycle after the strobe, then drop it
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_q <= `SSQ_CTRL_RST;
      list_q <= 16'h0;
      ival_q <= `SSQ_IVAL_RST;
      gap_q <= `SSQ_GAP_RST;
      ridx_q <= 16'h0;
      range_auto <= 1'b1;
      res_sel <= 2'h0;
    end
    else
    begin
      wb_ack_o <= acc;
      range_auto <= ctrl_q[`SSQ_C_AUTO];
      res_sel <= ctrl_q[`SSQ_C_RES_HI:`SSQ_C_RES_LO];
      if (wr)
      begin
        case (wb_adr_i)
          // Command bits self-clear; only mode bits are kept
          `SSQ_REG_CTRL: ctrl_q <= {wb_dat_i[11:3], 3'h0};
          `SSQ_REG_LIST: list_q <= wb_dat_i[15:0];
          `SSQ_REG_IVAL: ival_q <= wb_dat_i;
          `SSQ_REG_GAP: gap_q <= wb_dat_i;
          `SSQ_REG_RIDX: ridx_q <= wb_dat_i[15:0];
          default: ;
        endcase
      end
      if (rd)
      begin
        case (wb_adr_i)
          `SSQ_REG_CTRL: wb_dat_o <= {20'h0, ctrl_q};
          `SSQ_REG_LIST: wb_dat_o <= {16'h0, list_q};
          `SSQ_REG_IVAL: wb_dat_o <= ival_q;
          `SSQ_REG_GAP: wb_dat_o <= gap_q;
          `SSQ_REG_STAT: wb_dat_o <= {fill_q, 9'h0, ch_q, ovf_q, scan_active};
          `SSQ_REG_DIO: wb_dat_o <= {16'h0, din_b, din_a};
          `SSQ_REG_TOT: wb_dat_o <= {6'h0, tot_q};
          `SSQ_REG_RIDX: wb_dat_o <= {16'h0, ridx_q};
          `SSQ_REG_RDAT: wb_dat_o <= mem_dat[rphys];
          `SSQ_REG_RTS: wb_dat_o <= mem_ts[rphys];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== tb/ssq_monitor.sv ====
// Port checker of the scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.vh"
module ssq_monitor
(
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Bus as seen at the slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Measurement path
  input wire [3:0] mux_sel,
  input wire mux_en,
  input wire chan_closed,
  input wire meas_done,
  input wire range_auto,
  input wire [1:0] res_sel,
  input wire scan_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Steps
  // ****
  // Accepted lane-0 write to the control word
  sequence s_ctrl_wr;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `SSQ_REG_CTRL;
  endsequence
  // Two quiet cycles after a channel is released
  sequence s_quiet2;
    !chan_closed ##1 !chan_closed;
  endsequence
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  chk_meas_active: assert property (mux_en |-> scan_active)
    else $error("channel closed outside scan");
  chk_close_rise: assert property (chan_closed |-> $rose(mux_en))
    else $error("meter go without new channel");
  chk_chan_held: assert property (mux_en && !chan_closed |-> $stable(mux_sel))
    else $error("channel moved during measurement");
  chk_done_free: assert property (mux_en && meas_done && !chan_closed |=> !mux_en)
    else $error("channel kept after completion");
  chk_gap_min: assert property ($fell(mux_en) |-> s_quiet2)
    else $error("next channel too soon");
  chk_range_copy: assert property (s_ctrl_wr |-> ##2 ({res_sel, range_auto} == $past(wb_dat_i[10:8], 2)))
    else $error("range or resolution not applied");
  chk_start_run: assert property (s_ctrl_wr ##0 (wb_dat_i[0] && !wb_dat_i[1]) |-> ##[1:3] scan_active)
    else $error("start did not run");
endmodule
bind ssq_top ssq_monitor ssq_monitor_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .mux_sel, .mux_en, .chan_closed, .meas_done, .range_auto, .res_sel, .scan_active);
`default_nettype wire

// ==== tb/ssq_meter.sv ====
// Behavioural external meter answering each closed channel
`timescale 1ns/1ps
`default_nettype none
module ssq_meter
(
  // Clock
  input wire logic clk,
  // Go from the sequencer
  input wire logic chan_closed,
  input wire logic [3:0] mux_sel,
  // Completion
  output logic meas_done,
  output logic [21:0] meas_data
);
  int cnt = 0; // Cycles left, zero when idle
  logic [3:0] ch_q = 4'h0; // Channel being measured
  initial meas_done = 1'b0;
  initial meas_data = 22'h0;
  // Latency grows with the low three channel bits so answers come both prompt and slow
  always @(posedge clk)
  begin
    meas_done <= 1'b0;
    meas_data <= ~meas_data; // Not valid outside the completion cycle
    if (chan_closed === 1'b1)
    begin
      cnt <= mux_sel[2:0] + 1;
      ch_q <= mux_sel;
    end
    else if (cnt == 1)
    begin
      meas_done <= 1'b1;
      meas_data <= {ch_q, 18'h1a5a5};
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ==== tb/ssq_top_tb.sv ====
// Self-checking bench of the scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssq_consts.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module ssq_top_tb;
  // ****
  // Signals
  // ****
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic key_press = 1'b0;
  logic ext_trig = 1'b0;
  logic alarm_logged = 1'b0;
  logic [7:0] din_a = 8'h0;
  logic [7:0] din_b = 8'h0;
  logic tot_in = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [3:0] mux_sel;
  wire mux_en;
  wire chan_closed;
  wire meas_done;
  wire [21:0] meas_data;
  wire range_auto;
  wire [1:0] res_sel;
  wire scan_active;
  int n_mismatch = 0;
  int num_checks = 0;
  int gap_v = 0; // Programmed inter-channel wait
  int cyc_n = 0;
  int t_done = 0; // Cycle of the last completion
  int n;
  int s;
  logic [31:0] rs = 32'h3d; // Xorshift state
  logic [31:0] r;
  logic [31:0] q;
  logic [31:0] eq[$]; // Expected read data
  logic [31:0] em[$]; // Mask of checked bits
  logic [3:0] cq[$]; // Expected channel order
  always #4 clk = ~clk;
  ssq_top ssq_top_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .key_press, .ext_trig, .alarm_logged, .mux_sel, .mux_en, .chan_closed, .meas_done, .meas_data,
    .range_auto, .res_sel, .din_a, .din_b, .tot_in, .scan_active);
  ssq_meter ssq_meter_i (.clk, .chan_closed, .mux_sel, .meas_done, .meas_data);
  // ****
  // Helpers
  // ****
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Stored form of a meter reading
  function logic [31:0] mref(input logic [3:0] c);
    return {c, 6'h0, c, 18'h1a5a5};
  endfunction
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One classic cycle; the note for a read goes on the queue
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    output logic [31:0] rq);
    int i;
    i = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    if (!w)
    begin
      eq.push_back(d);
      em.push_back(m);
    end
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 50);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 32'h0, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, e, 32'hffffffff, q);
  endtask
  task rdent(input int i, input logic [31:0] e);
    wr(`SSQ_REG_RIDX, i);
    rd(`SSQ_REG_RDAT, e);
  endtask
  // Poll the fill count; a count that never matches ends the run
  task automatic wait_fill(input int f);
    int i;
    q = 32'h0;
    for (i = 0; i < 400 && q[31:15] !== f[16:0]; i++)
      wb(1'b0, `SSQ_REG_STAT, 32'h0, 32'h0, q);
    if (q[31:15] !== f[16:0])
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // ****
  // Output watcher
  // ****
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (meas_done === 1'b1)
      t_done <= cyc_n;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && em.size() > 0)
    begin
      `CHK("wb_dat_o", eq[0] & em[0], wb_dat_o & em[0])
      void'(eq.pop_front());
      void'(em.pop_front());
    end
    if (chan_closed === 1'b1)
    begin
      `CHK("gap", 1'b1, t_done == 0 || cyc_n - t_done >= gap_v + 3)
      `CHK("mux_sel", cq.size() > 0 ? cq[0] : 4'hx, mux_sel)
      if (cq.size() > 0)
        void'(cq.pop_front());
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`SSQ_REG_CTRL, {20'h0, `SSQ_CTRL_RST});
    rd(`SSQ_REG_IVAL, `SSQ_IVAL_RST);
    rd(`SSQ_REG_GAP, `SSQ_GAP_RST);
    rd(`SSQ_REG_STAT, 32'h0);
    rd(8'h3c, 32'h0);
    $display("test reset done");
    r = rnd();
    din_a <= r[7:0];
    din_b <= r[15:8];
    gap_v = 4;
    wr(`SSQ_REG_GAP, 32'h4);
    wr(`SSQ_REG_LIST, 32'hf024);
    cq = '{4'h2, 4'h5, 4'hc};
    wr(`SSQ_REG_CTRL, 32'h111);
    wr(`SSQ_REG_CTRL, 32'h114);
    wait_fill(6);
    rdent(0, mref(4'h2));
    rdent(1, mref(4'h5));
    rdent(2, mref(4'hc));
    rdent(3, {4'hd, 20'h0, r[7:0]});
    rdent(4, {4'he, 20'h0, r[15:8]});
    rdent(5, {4'hf, 28'h0});
    $display("test sweep done");
    gap_v = 0;
    wr(`SSQ_REG_GAP, 32'h0);
    wr(`SSQ_REG_LIST, 32'he001);
    cq.push_back(4'h0);
    wr(`SSQ_REG_CTRL, 32'hd11);
    wr(`SSQ_REG_CTRL, 32'hd14);
    wait_fill(3);
    rdent(1, {4'hd, 12'h0, r[15:8], r[7:0]});
    rdent(2, {4'hf, 28'h0});
    $display("test restart done");
    wr(`SSQ_REG_LIST, 32'h8);
    for (s = 1; s < 5; s++)
    begin
      wr(`SSQ_REG_CTRL, {26'h0, s[2:0], 3'h1});
      repeat (30) @(posedge clk);
      cq.push_back(4'h3);
      if (s == 2)
        wr(`SSQ_REG_CTRL, {26'h0, s[2:0], 3'h4});
      else
      begin
        key_press <= (s == 1);
        ext_trig <= (s == 3);
        alarm_logged <= (s == 4);
        @(posedge clk);
        key_press <= 1'b0;
        ext_trig <= 1'b0;
        alarm_logged <= 1'b0;
      end
      wait_fill(1);
    end
    wr(`SSQ_REG_IVAL, 32'h12c);
    cq = '{4'h3, 4'h3};
    wr(`SSQ_REG_CTRL, 32'h1);
    wait_fill(2);
    wr(`SSQ_REG_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    wb(1'b0, `SSQ_REG_STAT, 32'h0, 32'h1, q);
    $display("test sources done");
    n = 2 + rnd() % 5;
    repeat (n)
    begin
      tot_in <= 1'b1;
      repeat (`SSQ_TOT_MIN_CYC / 2) @(posedge clk);
      tot_in <= 1'b0;
      repeat (`SSQ_TOT_MIN_CYC / 2) @(posedge clk);
    end
    rd(`SSQ_REG_TOT, n);
    rd(`SSQ_REG_TOT, n);
    wr(`SSQ_REG_CTRL, 32'hc0);
    rd(`SSQ_REG_TOT, n);
    tot_in <= 1'b1;
    repeat (700) @(posedge clk);
    rd(`SSQ_REG_TOT, 32'h0);
    tot_in <= 1'b0;
    repeat (700) @(posedge clk);
    rd(`SSQ_REG_TOT, 32'h1);
    r = rnd();
    din_a <= r[7:0];
    din_b <= r[15:8];
    @(posedge clk);
    rd(`SSQ_REG_DIO, {16'h0, r[15:8], r[7:0]});
    $display("test counter and ports done");
    @(posedge clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
